/* hw/trace_cfg_pkg.sv */
// constants shared by the trace configuration scan chain
package trace_cfg_pkg;
   localparam int CHAIN_W = 40;               // total chain length
   localparam int DATA_W = 32;                // data field width
   localparam int ADDR_W = 7;                 // address field width
   localparam int DATA_LSB = 0;               // data field low bit
   localparam int ADDR_LSB = 32;              // address field low bit
   localparam int DIR_BIT = 39;               // read/write bit position
   localparam logic [3:0] CHAIN_SEL = 4'h6;   // chain number selecting us
   localparam int NUM_REGS = 128;             // registers behind the chain
   localparam logic [31:0] REG_RST = 32'h0000_0000; // register reset value
   localparam logic [39:0] CHAIN_RST = 40'h00_0000_0000; // chain reset
   // tap states that the chain cares about, one-hot
   typedef enum logic [3:0] {
      TS_IDLE = 4'b0001,
      TS_CAPTURE = 4'b0010,
      TS_SHIFT = 4'b0100,
      TS_UPDATE = 4'b1000
   } tap_phase_t;
endpackage

/* hw/trace_cfg_if.sv */
// carrier between chain front end and register array
`timescale 1ns/1ps
interface trace_cfg_if;
   logic access;             // one-cycle access pulse at update
   logic wr;                 // direction: 1 write, 0 read
   logic [6:0] addr;         // register address
   logic [31:0] wdata;       // write value
   logic [31:0] rdata;       // read value, registered
   modport front (output access, wr, addr, wdata, input rdata);
   modport regs (input access, wr, addr, wdata, output rdata);
endinterface

/* hw/trace_cfg_regs.sv */
// register array reached through the scan chain
`timescale 1ns/1ps
module trace_cfg_regs
   import trace_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   trace_cfg_if.regs bus
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [31:0] mem_q [NUM_REGS]; // register contents
   logic [31:0] rdata_q;          // latched read result
   logic [31:0] rdata_d;
   // read result chosen at access time
   always_comb begin
      rdata_d = rdata_q;
      if (bus.access && !bus.wr) begin
         rdata_d = mem_q[bus.addr];
      end
   end
   // write port and read latch
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= REG_RST;
         for (int i = 0; i < NUM_REGS; i++) begin
            mem_q[i] <= REG_RST;
         end
      end else begin
         rdata_q <= rdata_d;
         if (bus.access && bus.wr) begin
            mem_q[bus.addr] <= bus.wdata;
         end
      end
   end
   assign bus.rdata = rdata_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   write_lands_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (bus.access && bus.wr)
         |=> mem_q[$past(bus.addr)] == $past(bus.wdata))
      else $error("write did not reach the register");
   read_keeps_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (bus.access && !bus.wr)
         |=> mem_q[$past(bus.addr)] == $past(mem_q[bus.addr]))
      else $error("read changed the register");
   read_latch_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (bus.access && !bus.wr) |=> rdata_q == $past(mem_q[bus.addr]))
      else $error("read result not latched");
endmodule

/* hw/trace_cfg_scan_chain.sv */
// jtag scan chain front end for the trace configuration registers
// Functional notes
// - registers reachable only through tap chain six
// - forty-bit chain: data, address, direction bit
// - read uses direction zero, data ignored
// - access fires on entering update-dr only
`timescale 1ns/1ps
module trace_cfg_scan_chain
   import trace_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tck_i,           // jtag test clock
   input wire logic tdi_i,           // serial data in
   input wire logic capture_dr_i,    // tap in capture-dr
   input wire logic shift_dr_i,      // tap in shift-dr
   input wire logic update_dr_i,     // tap in update-dr
   input wire logic [3:0] chain_i,   // selected scan chain number
   output logic tdo_o,               // serial data out
   output logic access_o,            // pulse: register access done
   output logic [6:0] addr_o         // address of last access
);
   // ------------------------------------------------------------
   // input synchronisers, two stages each
   // ------------------------------------------------------------
   // the chain number is synchronised raw and compared afterwards; the
   // debugger must let it settle before capture-dr, as its bits may skew
   localparam int SYNC_W = 9;
   logic [SYNC_W-1:0] s1_q, s2_q; // first stage feeds second only
   logic [SYNC_W-1:0] raw; // pins as they arrive
   assign raw = {tck_i, tdi_i, capture_dr_i, shift_dr_i, update_dr_i,
                 chain_i};
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   logic tck_s, tdi_s, cap_s, sh_s, upd_s; // settled tap levels
   logic [3:0] chain_s; // settled chain number
   logic sel_s; // our chain is the selected one
   assign {tck_s, tdi_s, cap_s, sh_s, upd_s, chain_s} = s2_q;
   assign sel_s = (chain_s == CHAIN_SEL);

   // ------------------------------------------------------------
   // edge detection of the test clock
   // ------------------------------------------------------------
   logic tck_prev_q;              // last sampled test clock
   logic tck_rise, tck_fall;
   assign tck_rise = tck_s && !tck_prev_q;
   assign tck_fall = !tck_s && tck_prev_q;

   trace_cfg_if rbus ();
   trace_cfg_regs u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(rbus)
   );

   // ------------------------------------------------------------
   // chain state
   // ------------------------------------------------------------
   tap_phase_t phase_q, phase_d;  // tracked tap phase
   logic [CHAIN_W-1:0] sr_q, sr_d; // the 40-bit chain
   logic tdo_q, tdo_d; // serial output bit
   logic acc_q, acc_d; // access pulse
   logic [6:0] addr_q, addr_d; // address field at update
   logic wr_q, wr_d; // direction bit at update
   logic [31:0] wdata_q, wdata_d; // data field at update
   logic upd_seen_q, upd_seen_d;  // stops a second fire in one update

   // true on the cycle that update-dr is first seen for our chain;
   // shared by the access logic and its checks so both agree
   function automatic logic enters_update(input logic upd, input logic seen,
                                          input logic sel);
      return upd && !seen && sel;
   endfunction

   // next-state logic: capture and shift on tck rising edges, update on first sight of update-dr
   always_comb begin
      phase_d = phase_q;
      sr_d = sr_q;
      tdo_d = tdo_q;
      acc_d = 1'b0;
      addr_d = addr_q;
      wr_d = wr_q;
      wdata_d = wdata_q;
      upd_seen_d = upd_seen_q;
      if (!upd_s) begin
         upd_seen_d = 1'b0;
      end
      if (tck_rise && sel_s) begin // only chain six reacts
         case (phase_q)
            TS_IDLE, TS_CAPTURE, TS_SHIFT, TS_UPDATE: begin
               if (cap_s) begin
                  // last read result returns in the data field
                  phase_d = TS_CAPTURE;
                  sr_d[DATA_W-1:0] = rbus.rdata;
               end else if (sh_s) begin
                  // lsb first; tdi enters at the top
                  phase_d = TS_SHIFT;
                  sr_d = {tdi_s, sr_q[CHAIN_W-1:1]};
               end else begin
                  phase_d = TS_IDLE;
               end
            end
            default: phase_d = TS_IDLE;
         endcase
      end
      // tdo changes on the falling edge, as jtag expects
      if (tck_fall && sel_s) begin
         tdo_d = sr_q[0];
      end
      // fire once when update-dr is entered, never while shifting
      if (enters_update(upd_s, upd_seen_q, sel_s)) begin
         upd_seen_d = 1'b1;
         phase_d = TS_UPDATE;
         acc_d = 1'b1;
         addr_d = sr_q[ADDR_LSB +: ADDR_W];
         wr_d = sr_q[DIR_BIT];                // 1 write 0 read
         wdata_d = sr_q[DATA_LSB +: DATA_W];  // unused on reads
      end
   end

   // registers only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tck_prev_q <= 1'b0;
         phase_q <= TS_IDLE;
         sr_q <= CHAIN_RST;
         tdo_q <= 1'b0;
         acc_q <= 1'b0;
         addr_q <= '0;
         wr_q <= 1'b0;
         wdata_q <= REG_RST;
         upd_seen_q <= 1'b0;
      end else begin
         tck_prev_q <= tck_s;
         phase_q <= phase_d;
         sr_q <= sr_d;
         tdo_q <= tdo_d;
         acc_q <= acc_d;
         addr_q <= addr_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         upd_seen_q <= upd_seen_d;
      end
   end

   assign rbus.access = acc_q;
   assign rbus.wr = wr_q;
   assign rbus.addr = addr_q;
   assign rbus.wdata = wdata_q;
   assign tdo_o = tdo_q;
   assign access_o = acc_q;
   assign addr_o = addr_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // access pulse: once per update entry, never elsewhere
   update_fires_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      enters_update(upd_s, upd_seen_q, sel_s) |=> acc_q)
      else $error("update entry did not fire access");
   no_shift_fire_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!upd_s) |=> !acc_q)
      else $error("access fired outside update");
   single_fire_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      acc_q |=> !acc_q)
      else $error("access fired twice");
   held_update_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (upd_s && upd_seen_q) |=> !acc_q)
      else $error("held update fired again");
   other_fire_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!sel_s) |=> !acc_q)
      else $error("access fired for another chain");
   // chain movement: only when selected, lsb first
   other_chain_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!sel_s && tck_rise) |=> $stable(sr_q))
      else $error("chain moved while not selected");
   shift_lsb_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (sel_s && tck_rise && sh_s && !cap_s)
         |=> sr_q[38:0] == $past(sr_q[39:1]))
      else $error("chain did not shift lsb first");
   idle_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (sel_s && tck_rise && !cap_s && !sh_s) |=> $stable(sr_q))
      else $error("chain moved outside capture and shift");
   // field decoding at update entry
   dir_bit_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      enters_update(upd_s, upd_seen_q, sel_s) |=> wr_q == $past(sr_q[39]))
      else $error("direction bit misread");
   addr_field_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      enters_update(upd_s, upd_seen_q, sel_s)
         |=> addr_q == $past(sr_q[38:32]))
      else $error("address field misread");
   wdata_field_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      enters_update(upd_s, upd_seen_q, sel_s)
         |=> wdata_q == $past(sr_q[31:0]))
      else $error("data field misread");
   // serial path back to the debugger
   capture_read_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (sel_s && tck_rise && cap_s)
         |=> sr_q[31:0] == $past(rbus.rdata))
      else $error("read result not captured");
   tdo_out_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (sel_s && tck_fall) |=> tdo_q == $past(sr_q[0]))
      else $error("tdo did not follow chain bit zero");
endmodule

/* verification/jtag_dbg_model.sv */
// behavioural jtag debugger that scans the trace chain through the tap
`timescale 1ns/1ps
module jtag_dbg_model (
   input wire logic clk_i,
   input wire logic tdo_i,
   output logic tck_o,
   output logic tdi_o,
   output logic capture_o,
   output logic shift_o,
   output logic update_o,
   output logic [3:0] chain_o
);
   // tck stands low outside frames; levels only move while it is low
   initial begin
      tck_o = 1'b0;
      tdi_o = 1'b0;
      capture_o = 1'b0;
      shift_o = 1'b0;
      update_o = 1'b0;
      chain_o = 4'h0;
   end
   // one tck period of 800 ns
   task automatic tck_cycle();
      repeat (4) @(negedge clk_i);
      tck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      tck_o = 1'b0;
   endtask
   // capture, forty shifts lsb first, then update
   task automatic scan(input logic [3:0] chain, input logic [39:0] vec,
                       output logic [39:0] got);
      chain_o = chain;
      capture_o = 1'b1;
      tck_cycle();
      capture_o = 1'b0;
      shift_o = 1'b1;
      for (int i = 0; i < 40; i++) begin
         tdi_o = vec[i]; // field bits, lsb first
         repeat (4) @(negedge clk_i);
         got[i] = tdo_i; // tdo taken just before the rise
         tck_o = 1'b1;
         repeat (4) @(negedge clk_i);
         tck_o = 1'b0;
      end
      shift_o = 1'b0;
      tdi_o = ~tdi_o; // released line shows no stale bit
      update_o = 1'b1;
      tck_cycle();
      update_o = 1'b0;
   endtask
endmodule

/* verification/trace_cfg_scan_chain_bench.sv */
// self-checking bench for the trace configuration scan chain
`timescale 1ns/1ps
module trace_cfg_scan_chain_bench;
   import trace_cfg_pkg::*;
   logic clk_i, rst_i, tck_i, tdi_i, capture_dr_i, shift_dr_i, update_dr_i;
   logic [3:0] chain_i;
   logic tdo_o, access_o;
   logic [6:0] addr_o;
   logic [6:0] exp_addr = 7'h00; // address of last real access
   logic [31:0] rd;
   logic upd_q = 1'b0;
   logic acc_q = 1'b0;
   int bad_count = 0;
   int compares = 0;
   int acc_n = 0; // access pulses seen
   int lat = 0; // clk edges from update rise to access
   int since = 0;
   // ----------------------------------------
   // design and debugger
   // ----------------------------------------
   trace_cfg_scan_chain u_trace_cfg_scan_chain (.clk_i(clk_i),
      .rst_i(rst_i), .tck_i(tck_i), .tdi_i(tdi_i),
      .capture_dr_i(capture_dr_i), .shift_dr_i(shift_dr_i),
      .update_dr_i(update_dr_i), .chain_i(chain_i), .tdo_o(tdo_o),
      .access_o(access_o), .addr_o(addr_o));
   jtag_dbg_model u_jtag_dbg_model (.clk_i(clk_i), .tdo_i(tdo_o),
      .tck_o(tck_i), .tdi_o(tdi_i), .capture_o(capture_dr_i),
      .shift_o(shift_dr_i), .update_o(update_dr_i), .chain_o(chain_i));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // access monitor, sampled once the edge has settled
   always @(posedge clk_i) begin
      #1;
      since = (update_dr_i && !upd_q) ? 0 : since + 1;
      if (access_o === 1'b1) begin
         acc_n = acc_n + 1;
         lat = since;
      end
      if (acc_q === 1'b1) check({39'h0, access_o}, 40'h0); // one cycle
      upd_q = update_dr_i;
      acc_q = access_o;
   end
   // one full scan, then judge access count, latency and address
   task automatic op(input logic [3:0] ch, input logic wr,
                     input logic [6:0] a, input logic [31:0] d);
      logic [39:0] got;
      int n0;
      n0 = acc_n;
      u_jtag_dbg_model.scan(ch, {wr, a, d}, got);
      repeat (8) @(negedge clk_i);
      check(40'(acc_n - n0), (ch == CHAIN_SEL) ? 40'h1 : 40'h0);
      if (ch == CHAIN_SEL) begin
         exp_addr = a;
         check(40'(lat), 40'h2); // two sync stages, then register
      end
      check({33'h0, addr_o}, {33'h0, exp_addr});
      rd = got[31:0];
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      check({31'h0, tdo_o, access_o, addr_o}, 40'h0); // quiet outputs
   endtask
   task automatic test_write_read();
      op(4'h6, 1'b1, 7'h05, 32'hA5A5_5A5A);
      op(4'h6, 1'b0, 7'h05, 32'hFFFF_FFFF);
      op(4'h6, 1'b0, 7'h00, 32'h0000_0000);
      check({8'h0, rd}, {8'h0, 32'hA5A5_5A5A});
   endtask
   task automatic test_top_addr();
      op(4'h6, 1'b1, 7'h7F, 32'h1234_5678);
      op(4'h6, 1'b0, 7'h7F, 32'h0000_0000);
      op(4'h6, 1'b0, 7'h00, 32'h0000_0000);
      check({8'h0, rd}, {8'h0, 32'h1234_5678}); // top address
   endtask
   task automatic test_wrong_chain();
      op(4'h5, 1'b1, 7'h05, 32'hDEAD_BEEF);
      op(4'h6, 1'b0, 7'h05, 32'h0000_0000);
      check({8'h0, rd}, {8'h0, REG_RST}); // untouched register 0, read at the end of the previous test
      op(4'h6, 1'b0, 7'h00, 32'h0000_0000);
      check({8'h0, rd}, {8'h0, 32'hA5A5_5A5A}); // other chain ignored
   endtask
   // a reset in mid-run clears the registers behind the chain
   task automatic test_mid_reset();
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      check({31'h0, tdo_o, access_o, addr_o}, 40'h0); // quiet again
      exp_addr = 7'h00;
      op(4'h6, 1'b0, 7'h05, 32'h0000_0000);
      op(4'h6, 1'b0, 7'h00, 32'h0000_0000);
      check({8'h0, rd}, {8'h0, REG_RST}); // back to reset value
   endtask
   task automatic final_report();
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog: the full run needs about 3800 clk cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count = bad_count + 1;
      final_report();
   end
   initial begin
      rst_i = 1'b1;
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      test_reset();
      test_write_read();
      test_top_addr();
      test_wrong_chain();
      test_mid_reset();
      final_report();
   end
endmodule
